// [src/pll_serial_host.sv]
`default_nettype none
module pll_serial_host #(
  parameter int unsigned HALF_CYC = pll_load_pkg::T_MIN_CYC
) (
  // System
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // AXI4-Lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Serial link
  serial_load_if.host      link
);
  localparam int unsigned TW = $clog2(HALF_CYC + 1);
  localparam logic [TW-1:0] T_LOAD = TW'(HALF_CYC - 1);

  typedef enum logic [4:0] {
    S_IDLE   = 5'h01,
    S_LOW    = 5'h02,
    S_HIGH   = 5'h04,
    S_STROBE = 5'h08,
    S_GAP    = 5'h10
  } link_state_e;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == pll_load_pkg::OFS_MAIN) ||
             (a == pll_load_pkg::OFS_REF) ||
             (a == pll_load_pkg::OFS_CMD) ||
             (a == pll_load_pkg::OFS_STATUS);
  endfunction

  // ****************************************************
  // Register bus
  // ****************************************************
  logic        aw_got_q, aw_got_d, w_got_q, w_got_d;
  logic [7:0]  awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0]  wstrb_q, wstrb_d;
  logic        awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
  logic [1:0]  bresp_d, rresp_d;
  logic [31:0] rdata_d;
  logic [17:0] main_reg_q, main_reg_d;
  logic [13:0] ref_reg_q, ref_reg_d;
  logic [2:0]  cmd_q, cmd_d;
  logic        err_clr_q, err_clr_d;
  logic [31:0] status;
  logic [31:0] mw;

  link_state_e state_q, state_d;
  logic        main_done_q, ref_done_q, err_q;

  always_comb begin
    status = '0;
    status[pll_load_pkg::ST_BUSY]      = (state_q != S_IDLE);
    status[pll_load_pkg::ST_MAIN_DONE] = main_done_q;
    status[pll_load_pkg::ST_REF_DONE]  = ref_done_q;
    status[pll_load_pkg::ST_RANGE_ERR] = err_q;
    aw_got_d  = aw_got_q;
    w_got_d   = w_got_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = s_axi_bvalid & ~s_axi_bready;
    bresp_d   = s_axi_bresp;
    rvalid_d  = s_axi_rvalid & ~s_axi_rready;
    rresp_d   = s_axi_rresp;
    rdata_d   = s_axi_rdata;
    main_reg_d = main_reg_q;
    ref_reg_d  = ref_reg_q;
    cmd_d      = '0;
    err_clr_d  = 1'b0;
    mw         = '0;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_got_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_got_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (aw_got_q && w_got_q && !s_axi_bvalid) begin
      aw_got_d = 1'b0;
      w_got_d  = 1'b0;
      bvalid_d = 1'b1;
      bresp_d  = mapped(awaddr_q) ? pll_load_pkg::RESP_OKAY
                                  : pll_load_pkg::RESP_SLVERR;
      unique case (awaddr_q)
        pll_load_pkg::OFS_MAIN: begin
          mw = merge({14'h0000, main_reg_q}, wdata_q, wstrb_q);
          main_reg_d = mw[17:0];
        end
        pll_load_pkg::OFS_REF: begin
          mw = merge({18'h00000, ref_reg_q}, wdata_q, wstrb_q);
          ref_reg_d = mw[13:0];
        end
        pll_load_pkg::OFS_CMD: begin
          cmd_d = wstrb_q[0] ? wdata_q[2:0] : 3'h0;
        end
        pll_load_pkg::OFS_STATUS: begin
          err_clr_d = wstrb_q[0] & wdata_q[pll_load_pkg::ST_RANGE_ERR];
        end
        default: begin
        end
      endcase
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d  = mapped(s_axi_araddr) ? pll_load_pkg::RESP_OKAY
                                      : pll_load_pkg::RESP_SLVERR;
      unique case (s_axi_araddr)
        pll_load_pkg::OFS_MAIN:   rdata_d = {14'h0000, main_reg_q};
        pll_load_pkg::OFS_REF:    rdata_d = {18'h00000, ref_reg_q};
        pll_load_pkg::OFS_STATUS: rdata_d = status;
        default:                  rdata_d = '0;
      endcase
    end
    awready_d = ~aw_got_d & ~bvalid_d;
    wready_d  = ~w_got_d & ~bvalid_d;
    arready_d = ~rvalid_d;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      aw_got_q      <= 1'b0;
      w_got_q       <= 1'b0;
      awaddr_q      <= '0;
      wdata_q       <= '0;
      wstrb_q       <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= pll_load_pkg::RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= pll_load_pkg::RESP_OKAY;
      s_axi_rdata   <= '0;
      main_reg_q    <= pll_load_pkg::RATIO_RESET[17:0];
      ref_reg_q     <= pll_load_pkg::RATIO_RESET[13:0];
      cmd_q         <= '0;
      err_clr_q     <= 1'b0;
    end else begin
      aw_got_q      <= aw_got_d;
      w_got_q       <= w_got_d;
      awaddr_q      <= awaddr_d;
      wdata_q       <= wdata_d;
      wstrb_q       <= wstrb_d;
      s_axi_awready <= awready_d;
      s_axi_wready  <= wready_d;
      s_axi_bvalid  <= bvalid_d;
      s_axi_bresp   <= bresp_d;
      s_axi_arready <= arready_d;
      s_axi_rvalid  <= rvalid_d;
      s_axi_rresp   <= rresp_d;
      s_axi_rdata   <= rdata_d;
      main_reg_q    <= main_reg_d;
      ref_reg_q     <= ref_reg_d;
      cmd_q         <= cmd_d;
      err_clr_q     <= err_clr_d;
    end
  end

  // ****************************************************
  // Serial frame engine
  // ****************************************************
  logic [19:0]   frame_q, frame_d;
  logic [4:0]    left_q, left_d;
  logic [TW-1:0] timer_q, timer_d;
  logic          sel_ref_q, sel_ref_d;
  logic          init_q, init_d;
  logic          sclk_q, sclk_d, sdata_q, sdata_d, strobe_q, strobe_d;
  logic          main_done_d, ref_done_d, err_d;
  logic          main_ok, ref_ok, both;
  logic [19:0]   main_frame, ref_frame;

  assign link.serial_clk   = sclk_q;
  assign link.serial_data  = sdata_q;
  assign link.latch_strobe = strobe_q;

  always_comb begin
    main_frame = {pll_load_pkg::SEL_MAIN, main_reg_q};
    ref_frame  = '0;
    ref_frame[13:0] = ref_reg_q;
    ref_frame[pll_load_pkg::REF_SEL0_POS] = pll_load_pkg::SEL_REF[0];
    ref_frame[pll_load_pkg::REF_SEL1_POS] = pll_load_pkg::SEL_REF[1];
    main_ok = (main_reg_q[17:6] >= 12'(pll_load_pkg::MIN_COUNT));
    ref_ok  = (ref_reg_q >= 14'(pll_load_pkg::MIN_COUNT));
    both    = cmd_q[pll_load_pkg::CMD_INIT] |
              (cmd_q[pll_load_pkg::CMD_MAIN] & cmd_q[pll_load_pkg::CMD_REF]);
    state_d     = state_q;
    frame_d     = frame_q;
    left_d      = left_q;
    timer_d     = (timer_q != '0) ? timer_q - TW'(1) : timer_q;
    sel_ref_d   = sel_ref_q;
    init_d      = init_q;
    sclk_d      = sclk_q;
    sdata_d     = sdata_q;
    strobe_d    = strobe_q;
    main_done_d = main_done_q;
    ref_done_d  = ref_done_q;
    err_d       = err_q & ~err_clr_q;
    unique case (state_q)
      S_IDLE: begin
        if (cmd_q != '0 && (!main_ok && (both ||
            cmd_q[pll_load_pkg::CMD_MAIN]) ||
            !ref_ok && (both || cmd_q[pll_load_pkg::CMD_REF]))) begin
          err_d = 1'b1;
        end else if (both || cmd_q[pll_load_pkg::CMD_REF]) begin
          init_d    = both;
          sel_ref_d = 1'b1;
          frame_d   = ref_frame;
          left_d    = 5'(pll_load_pkg::REF_LEN - 1);
          sdata_d   = ref_frame[0];
          timer_d   = T_LOAD;
          state_d   = S_LOW;
        end else if (cmd_q[pll_load_pkg::CMD_MAIN]) begin
          sel_ref_d = 1'b0;
          frame_d   = main_frame;
          left_d    = 5'(pll_load_pkg::MAIN_LEN - 1);
          sdata_d   = main_frame[0];
          timer_d   = T_LOAD;
          state_d   = S_LOW;
        end
      end
      S_LOW: begin
        if (timer_q == '0) begin
          sclk_d  = 1'b1;
          timer_d = T_LOAD;
          state_d = S_HIGH;
        end
      end
      S_HIGH: begin
        if (timer_q == '0) begin
          sclk_d  = 1'b0;
          timer_d = T_LOAD;
          if (left_q == '0) begin
            strobe_d = 1'b1;
            state_d  = S_STROBE;
          end else begin
            frame_d = {1'b0, frame_q[19:1]};
            sdata_d = frame_q[1];
            left_d  = left_q - 5'h01;
            state_d = S_LOW;
          end
        end
      end
      S_STROBE: begin
        if (timer_q == '0) begin
          strobe_d    = 1'b0;
          main_done_d = main_done_q | ~sel_ref_q;
          ref_done_d  = ref_done_q | sel_ref_q;
          timer_d     = T_LOAD;
          state_d     = S_GAP;
        end
      end
      S_GAP: begin
        if (timer_q == '0) begin
          if (init_q) begin
            init_d    = 1'b0;
            sel_ref_d = 1'b0;
            frame_d   = main_frame;
            left_d    = 5'(pll_load_pkg::MAIN_LEN - 1);
            sdata_d   = main_frame[0];
            timer_d   = T_LOAD;
            state_d   = S_LOW;
          end else begin
            state_d = S_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q     <= S_IDLE;
      frame_q     <= '0;
      left_q      <= '0;
      timer_q     <= '0;
      sel_ref_q   <= 1'b0;
      init_q      <= 1'b0;
      sclk_q      <= 1'b0;
      sdata_q     <= 1'b0;
      strobe_q    <= 1'b0;
      main_done_q <= 1'b0;
      ref_done_q  <= 1'b0;
      err_q       <= 1'b0;
    end else begin
      state_q     <= state_d;
      frame_q     <= frame_d;
      left_q      <= left_d;
      timer_q     <= timer_d;
      sel_ref_q   <= sel_ref_d;
      init_q      <= init_d;
      sclk_q      <= sclk_d;
      sdata_q     <= sdata_d;
      strobe_q    <= strobe_d;
      main_done_q <= main_done_d;
      ref_done_q  <= ref_done_d;
      err_q       <= err_d;
    end
  end
endmodule
`default_nettype wire

// [include/pll_load_pkg.sv]
`default_nettype none
package pll_load_pkg;
  // ****************************************************
  // Frame layout, LSB sent first, select bits sent last
  // ****************************************************
  localparam int unsigned SHIFT_W       = 20;
  localparam int unsigned MAIN_LEN      = 20;
  localparam int unsigned REF_LEN       = 16;
  localparam int unsigned SWALLOW_W     = 6;
  localparam int unsigned MAIN_W        = 12;
  localparam int unsigned REF_W         = 14;
  localparam int unsigned SWALLOW_LSB   = 0;
  localparam int unsigned MAIN_LSB      = 6;
  // Positions once a frame has fully entered the shift register
  localparam int unsigned REF_LSB       = 4;
  localparam int unsigned SEL0_POS      = 18;
  localparam int unsigned SEL1_POS      = 19;
  // Positions inside a reference frame as the host builds it
  localparam int unsigned REF_SEL0_POS  = 14;
  localparam int unsigned REF_SEL1_POS  = 15;
  localparam int unsigned MIN_COUNT     = 5;
  localparam logic [1:0]  SEL_MAIN      = 2'h0;
  localparam logic [1:0]  SEL_REF       = 2'h2;

  // ****************************************************
  // Host registers
  // ****************************************************
  localparam logic [7:0]  OFS_MAIN      = 8'h00;
  localparam logic [7:0]  OFS_REF       = 8'h04;
  localparam logic [7:0]  OFS_CMD       = 8'h08;
  localparam logic [7:0]  OFS_STATUS    = 8'h0C;
  localparam int unsigned CMD_MAIN      = 0;
  localparam int unsigned CMD_REF       = 1;
  localparam int unsigned CMD_INIT      = 2;
  localparam int unsigned ST_BUSY       = 0;
  localparam int unsigned ST_MAIN_DONE  = 1;
  localparam int unsigned ST_REF_DONE   = 2;
  localparam int unsigned ST_RANGE_ERR  = 3;
  localparam logic [31:0] RATIO_RESET   = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // ****************************************************
  // Timing
  // ****************************************************
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned T_MIN_NS      = 500;
  localparam int unsigned T_MIN_CYC     =
    (T_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// [include/serial_load_if.sv]
`default_nettype none
interface serial_load_if;
  logic serial_clk;
  logic serial_data;
  logic latch_strobe;

  modport host (
    output serial_clk,
    output serial_data,
    output latch_strobe
  );

  modport device (
    input serial_clk,
    input serial_data,
    input latch_strobe
  );
endinterface
`default_nettype wire

// [src/pll_serial_device.sv]
`default_nettype none
module pll_serial_device (
  // System
  input  wire logic                        sys_clk,
  input  wire logic                        resetn,
  // Serial link
  serial_load_if.device                    link,
  // Latched ratios
  output var  logic [5:0]                  swallow_count_q,
  output var  logic [11:0]                 main_count_q,
  output var  logic [13:0]                 ref_count_q,
  output var  logic                        main_loaded_q,
  output var  logic                        ref_loaded_q
);
  // ****************************************************
  // Link domain shift register
  // ****************************************************
  logic [pll_load_pkg::SHIFT_W-1:0] shift_q;
  logic [pll_load_pkg::SHIFT_W-1:0] shift_d;

  // New bit enters on top, oldest falls off bit 0
  always_comb begin
    shift_d = {link.serial_data, shift_q[pll_load_pkg::SHIFT_W-1:1]};
  end

  always_ff @(posedge link.serial_clk or negedge resetn) begin
    if (!resetn) begin
      shift_q <= '0;
    end else begin
      shift_q <= shift_d;
    end
  end

  // ****************************************************
  // Strobe crossing and divider latches
  // ****************************************************
  function automatic logic [1:0] divider_select_bits(
    input logic [pll_load_pkg::SHIFT_W-1:0] s);
    divider_select_bits = {s[pll_load_pkg::SEL1_POS],
                           s[pll_load_pkg::SEL0_POS]};
  endfunction

  logic        strobe_m_q;
  logic        strobe_s_q;
  logic        strobe_p_q;
  logic        strobe_rise;
  logic [5:0]  swallow_count_d;
  logic [11:0] main_count_d;
  logic [13:0] ref_count_d;
  logic        main_loaded_d;
  logic        ref_loaded_d;

  // Shift register is quiet while the strobe is high, so sampling
  // it after the synchronised rise is safe
  always_comb begin
    strobe_rise     = strobe_s_q & ~strobe_p_q;
    swallow_count_d = swallow_count_q;
    main_count_d    = main_count_q;
    ref_count_d     = ref_count_q;
    main_loaded_d   = main_loaded_q;
    ref_loaded_d    = ref_loaded_q;
    if (strobe_rise &&
        divider_select_bits(shift_q) == pll_load_pkg::SEL_MAIN) begin
      swallow_count_d = shift_q[pll_load_pkg::SWALLOW_LSB +: 6];
      main_count_d    = shift_q[pll_load_pkg::MAIN_LSB +: 12];
      main_loaded_d   = 1'b1;
    end
    if (strobe_rise &&
        divider_select_bits(shift_q) == pll_load_pkg::SEL_REF) begin
      ref_count_d  = shift_q[pll_load_pkg::REF_LSB +: 14];
      ref_loaded_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      strobe_m_q      <= 1'b0;
      strobe_s_q      <= 1'b0;
      strobe_p_q      <= 1'b0;
      swallow_count_q <= '0;
      main_count_q    <= '0;
      ref_count_q     <= '0;
      main_loaded_q   <= 1'b0;
      ref_loaded_q    <= 1'b0;
    end else begin
      strobe_m_q      <= link.latch_strobe;
      strobe_s_q      <= strobe_m_q;
      strobe_p_q      <= strobe_s_q;
      swallow_count_q <= swallow_count_d;
      main_count_q    <= main_count_d;
      ref_count_q     <= ref_count_d;
      main_loaded_q   <= main_loaded_d;
      ref_loaded_q    <= ref_loaded_d;
    end
  end
endmodule
`default_nettype wire

// [test/pll_link_checker.sv]
`default_nettype none
module pll_link_checker #(
  parameter int unsigned HALF_CYC = 4
) (
  // System
  input wire logic sys_clk,
  input wire logic resetn,
  // Serial link
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic latch_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************
  // Frame tracking
  // ****************************************************
  logic        sclk_q;
  logic        sclk_d;
  logic [19:0] shift_q;
  logic [19:0] shift_d;
  logic [5:0]  nbits_q;
  logic [5:0]  nbits_d;
  logic [7:0]  hi_q;
  logic [7:0]  hi_d;

  always_comb begin
    sclk_d  = serial_clk;
    shift_d = shift_q;
    nbits_d = nbits_q;
    if (serial_clk && !sclk_q) begin
      shift_d = {serial_data, shift_q[19:1]};
      nbits_d = nbits_q + 6'h01;
    end
    if (latch_strobe) begin
      nbits_d = 6'h00;
    end
    hi_d = latch_strobe ? hi_q + 8'h01 : 8'h00;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sclk_q  <= 1'b0;
      shift_q <= 20'h00000;
      nbits_q <= 6'h00;
      hi_q    <= 8'h00;
    end else begin
      sclk_q  <= sclk_d;
      shift_q <= shift_d;
      nbits_q <= nbits_d;
      hi_q    <= hi_d;
    end
  end

  // ****************************************************
  // Link assertions
  // ****************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  property p_strobe_clk_low;
    latch_strobe |-> !serial_clk;
  endproperty
  a_strobe_clk_low: assert property (p_strobe_clk_low)
    else $error("strobe while link clock high");

  property p_strobe_width;
    $fell(latch_strobe) |-> hi_q == 8'(HALF_CYC);
  endproperty
  a_strobe_width: assert property (p_strobe_width)
    else $error("strobe pulse width wrong");

  property p_gap_after_strobe;
    $fell(latch_strobe) |-> !serial_clk [*4];
  endproperty
  a_gap_after_strobe: assert property (p_gap_after_strobe)
    else $error("shifting resumed too soon after strobe");

  property p_frame_len;
    $rose(latch_strobe) |-> nbits_q == 6'h14 || nbits_q == 6'h10;
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("frame length wrong");

  property p_sel_first;
    $rose(latch_strobe) |-> !shift_q[18];
  endproperty
  a_sel_first: assert property (p_sel_first)
    else $error("first select bit set");

  property p_main_sel;
    $rose(latch_strobe) && nbits_q == 6'h14 |-> !shift_q[19];
  endproperty
  a_main_sel: assert property (p_main_sel)
    else $error("main frame select wrong");

  property p_ref_sel;
    $rose(latch_strobe) && nbits_q == 6'h10 |-> shift_q[19];
  endproperty
  a_ref_sel: assert property (p_ref_sel)
    else $error("reference frame select wrong");

  property p_main_min;
    $rose(latch_strobe) && nbits_q == 6'h14 |-> shift_q[17:6] >= 12'h005;
  endproperty
  a_main_min: assert property (p_main_min)
    else $error("main count below five sent");

  property p_ref_min;
    $rose(latch_strobe) && nbits_q == 6'h10 |-> shift_q[17:4] >= 14'h0005;
  endproperty
  a_ref_min: assert property (p_ref_min)
    else $error("reference count below five sent");
endmodule
`default_nettype wire

// [test/tb.sv]
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk;
  logic        resetn;
  logic [7:0]  awaddr;
  logic [7:0]  araddr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [31:0] d;
  logic [3:0]  wstrb;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp, resp;
  logic [5:0]  sw_a, sw_b;
  logic [11:0] mn_a, mn_b;
  logic [13:0] rf_a, rf_b;
  logic        ml_a, ml_b, rl_a, rl_b;
  int          n_fail, comparisons, cyc;

  serial_load_if lk ();
  serial_load_if lk2 ();

  pll_serial_host #(.HALF_CYC(4)) i_pll_serial_host (
    .sys_clk(sys_clk), .resetn(resetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link(lk));
  pll_serial_device i_pll_serial_device (
    .sys_clk(sys_clk), .resetn(resetn), .link(lk),
    .swallow_count_q(sw_a), .main_count_q(mn_a), .ref_count_q(rf_a),
    .main_loaded_q(ml_a), .ref_loaded_q(rl_a));
  pll_serial_device i_pll_serial_device_b (
    .sys_clk(sys_clk), .resetn(resetn), .link(lk2),
    .swallow_count_q(sw_b), .main_count_q(mn_b), .ref_count_q(rf_b),
    .main_loaded_q(ml_b), .ref_loaded_q(rl_b));
  pll_link_checker #(.HALF_CYC(4)) i_chk (
    .sys_clk(sys_clk), .resetn(resetn), .serial_clk(lk.serial_clk),
    .serial_data(lk.serial_data), .latch_strobe(lk.latch_strobe));

  // ****************************************************
  // Clock, watchdog, verdict
  // ****************************************************
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic results;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      n_fail++;
      $display("[ERR] %0t watchdog expired", $time);
      results;
    end
  end

  // ****************************************************
  // Access tasks
  // ****************************************************
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    output logic [1:0] r);
    @(posedge sys_clk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] r);
    @(posedge sys_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic wait_idle;
    d = 32'h0000_0001;
    repeat (400) if (d[0] !== 1'b0) rd(pll_load_pkg::OFS_STATUS, d, resp);
    if (d[0] !== 1'b0) begin
      n_fail++;
      $display("[ERR] %0t link engine stayed busy", $time);
    end
  endtask

  // Bench-made link: 30 ns clock only within frames, LSB first
  task automatic send2(input logic [23:0] v);
    for (int i = 0; i < 24; i++) begin
      lk2.serial_data = v[i];
      #15 lk2.serial_clk = 1'b1;
      #15 lk2.serial_clk = 1'b0;
    end
    lk2.serial_data = ~lk2.serial_data;
    #15 lk2.latch_strobe = 1'b1;
    #30 lk2.latch_strobe = 1'b0;
    #30;
    repeat (8) @(posedge sys_clk);
  endtask

  // ****************************************************
  // Main sequence
  // ****************************************************
  initial begin
    n_fail = 0;
    comparisons = 0;
    cyc = 0;
    resetn = 1'b0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    lk2.serial_clk = 1'b0;
    lk2.serial_data = 1'b0;
    lk2.latch_strobe = 1'b0;
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    chk({ml_a, rl_a, rf_a, mn_a, sw_a}, 32'h0);
    rd(pll_load_pkg::OFS_STATUS, d, resp);
    chk(d, 32'h0);
    wr(8'h10, 32'h1, resp);
    chk(resp, pll_load_pkg::RESP_SLVERR);
    rd(8'h10, d, resp);
    chk({resp, d}, {pll_load_pkg::RESP_SLVERR, 32'h0});
    // Power-on load of both dividers, boundary ratios
    wr(pll_load_pkg::OFS_MAIN, {14'h0, 12'h005, 6'h3F}, resp);
    wr(pll_load_pkg::OFS_REF, {18'h0, 14'h3FFF}, resp);
    wr(pll_load_pkg::OFS_CMD, 32'h4, resp);
    chk(resp, pll_load_pkg::RESP_OKAY);
    wait_idle;
    chk(sw_a, 6'h3F);
    chk(mn_a, 12'h005);
    chk(rf_a, 14'h3FFF);
    chk({ml_a, rl_a, d}, {2'h3, 32'h6});
    // One frame updates one divider only
    wr(pll_load_pkg::OFS_REF, 32'h5, resp);
    wr(pll_load_pkg::OFS_CMD, 32'h2, resp);
    wait_idle;
    chk({rf_a, mn_a}, {14'h0005, 12'h005});
    wr(pll_load_pkg::OFS_MAIN, {14'h0, 12'hFFF, 6'h00}, resp);
    wr(pll_load_pkg::OFS_CMD, 32'h1, resp);
    wait_idle;
    chk({rf_a, mn_a, sw_a}, {14'h0005, 18'h3FFC0});
    // Counts below five send no frame
    wr(pll_load_pkg::OFS_MAIN, {14'h0, 12'h004, 6'h01}, resp);
    wr(pll_load_pkg::OFS_CMD, 32'h1, resp);
    wait_idle;
    chk({d, mn_a, sw_a}, {32'hE, 18'h3FFC0});
    wr(pll_load_pkg::OFS_STATUS, 32'h8, resp);
    rd(pll_load_pkg::OFS_STATUS, d, resp);
    chk(d, 32'h6);
    wr(pll_load_pkg::OFS_REF, 32'h4, resp);
    wr(pll_load_pkg::OFS_CMD, 32'h2, resp);
    wait_idle;
    chk({d, rf_a}, {32'hE, 14'h0005});
    // Over-long frames and a frame for neither divider
    send2({2'b00, 12'hFFF, 6'h01, 4'hA});
    chk({ml_b, rl_b, mn_b, sw_b}, {2'h2, 18'h3FFC1});
    send2({2'b10, 14'h0006, 8'hC3});
    chk({rl_b, rf_b, mn_b}, {1'b1, 14'h0006, 12'hFFF});
    send2({2'b11, 14'h0007, 8'h00});
    chk({rf_b, mn_b, sw_b}, {14'h0006, 18'h3FFC1});
    results;
  end
endmodule
`default_nettype wire
